// [hdl/eps_pkg.sv]
// Constants, register map and types of the encoder position step sequencer
package eps_pkg;
    // Register byte offsets
    localparam logic [8:0] REG_CTRL      = 9'h000;
    localparam logic [8:0] REG_CNT_UNIT  = 9'h004;
    localparam logic [8:0] REG_TOL       = 9'h008;
    localparam logic [8:0] REG_POSITION  = 9'h00C;
    localparam logic [8:0] REG_STATUS    = 9'h010;
    localparam logic [8:0] REG_IRQ_STAT  = 9'h014;
    localparam logic [8:0] REG_IRQ_CLR   = 9'h018;
    localparam logic [8:0] REG_IRQ_EN    = 9'h01C;
    localparam logic [8:0] REG_LOSS_LIM  = 9'h020;
    localparam logic [8:0] REG_CMD_POS   = 9'h024;
    // Step table: base + step * 0x20 + field * 4
    localparam int         TBL_BIT       = 8;
    localparam logic [2:0] FLD_WHOLE     = 3'h0;
    localparam logic [2:0] FLD_FRAC      = 3'h1;
    localparam logic [2:0] FLD_FREQ      = 3'h2;
    localparam logic [2:0] FLD_DWELL     = 3'h3;
    localparam logic [2:0] FLD_LOGIC     = 3'h4;
    // CTRL fields
    localparam int CTRL_SRC_LSB  = 0;
    localparam int CTRL_FB_LSB   = 4;
    localparam int CTRL_MODE_LSB = 8;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [15:0] CNT_UNIT_RST = 16'h0001;
    localparam logic [15:0] TOL_RST      = 16'h0000;
    localparam logic [15:0] LOSS_LIM_RST = 16'h0010;
    // Codes
    localparam logic [3:0] SRC_POSITION   = 4'h9;
    localparam logic [2:0] FB_NONE        = 3'h0;
    localparam logic [2:0] FB_PULSE       = 3'h1;
    localparam logic [2:0] FB_SINGLE      = 3'h2;
    localparam logic [2:0] FB_SINGLE_CHK  = 3'h3;
    localparam logic [2:0] FB_QUAD        = 3'h4;
    localparam logic [2:0] FB_QUAD_CHK    = 3'h5;
    localparam logic [2:0] MODE_TIMED     = 3'h0;
    localparam logic [2:0] MODE_PRESET    = 3'h1;
    localparam logic [2:0] MODE_STEP      = 3'h2;
    localparam logic [2:0] MODE_INPUT_START = 3'h3;
    localparam logic [2:0] MODE_RESUME_LAST = 3'h4;
    localparam logic [3:0] LOGIC_IGNORE   = 4'hF;
    localparam logic [3:0] JUMP_END_NORMAL = 4'h8;
    localparam logic [3:0] JUMP_END_COAST  = 4'h9;
    localparam logic [3:0] JUMP_END_FAULT  = 4'hA;
    // Interrupt bits
    localparam int IRQ_AT_POS = 0;
    localparam int IRQ_STEP   = 1;
    localparam int IRQ_END    = 2;
    localparam int IRQ_FAULT  = 3;
    localparam int IRQ_W      = 4;
    // Fraction is entered in hundredths; 2^20/100 rounded
    localparam logic [13:0] FRAC_SCALE = 14'h28F6;
    localparam int          FRAC_SHIFT = 20;
    // Timing at 40 MHz
    localparam int CLK_PERIOD_NS = 25;
    localparam int DWELL_UNIT_NS = 100_000_000;
    localparam int DWELL_UNIT_CYC = DWELL_UNIT_NS / CLK_PERIOD_NS;
    localparam int LOSS_WIN_NS   = 1_000_000;
    localparam int LOSS_WIN_CYC  = LOSS_WIN_NS / CLK_PERIOD_NS;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_RUN  = 4'b0100,
        ST_END  = 4'b1000
    } eps_state_t;
endpackage

// [hdl/eps_step_mem.sv]
// Eight-entry step table with registered read port
module eps_step_mem
    import eps_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        we_i,
    input  wire logic [2:0]  wr_step_i,
    input  wire logic [2:0]  wr_field_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic [2:0]  rd_step_i,
    output logic      [15:0] whole_o,
    output logic      [6:0]  frac_o,
    output logic      [15:0] freq_o,
    output logic      [15:0] dwell_o,
    output logic      [15:0] logic_o
);
    logic [15:0] whole_mem [8];
    logic [6:0]  frac_mem  [8];
    logic [15:0] freq_mem  [8];
    logic [15:0] dwell_mem [8];
    logic [15:0] logic_mem [8];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            unique case (wr_field_i)
                FLD_WHOLE: whole_mem[wr_step_i] <= wr_data_i;
                FLD_FRAC:  frac_mem[wr_step_i]  <= wr_data_i[6:0];
                FLD_FREQ:  freq_mem[wr_step_i]  <= wr_data_i;
                FLD_DWELL: dwell_mem[wr_step_i] <= wr_data_i;
                FLD_LOGIC: logic_mem[wr_step_i] <= wr_data_i;
                default: ;
            endcase
        end
        whole_o <= whole_mem[rd_step_i];
        frac_o  <= frac_mem[rd_step_i];
        freq_o  <= freq_mem[rd_step_i];
        dwell_o <= dwell_mem[rd_step_i];
        logic_o <= logic_mem[rd_step_i];
    end
endmodule // eps_step_mem

// [hdl/eps_seq.sv]
// Encoder position step sequencer with Wishbone registers
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
module eps_seq
    import eps_pkg::*;
#(
    parameter int DWELL_CYC = DWELL_UNIT_CYC,
    parameter int LOSS_CYC  = LOSS_WIN_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [8:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    input  wire logic        enc_a_i,
    input  wire logic        enc_b_i,
    input  wire logic        run_i,
    input  wire logic        logic_in1_i,
    input  wire logic        logic_in2_i,
    input  wire logic [2:0]  preset_sel_i,
    input  wire logic [15:0] expected_cnt_i,
    output logic      [31:0] cmd_position_o,
    output logic      [15:0] freq_limit_o,
    output logic      [2:0]  step_o,
    output logic             accel2_sel_o,
    output logic             step_output_o,
    output logic             at_position_o,
    output logic             pos_active_o,
    output logic             stop_normal_o,
    output logic             stop_coast_o,
    output logic             fault_o,
    output logic             irq_o
);
    // Bus decode
    wire        bus_req  = cyc_i & stb_i & ~ack_o;
    wire        bus_wr   = bus_req & we_i & (&sel_i);
    wire        tbl_hit  = adr_i[TBL_BIT];
    wire [2:0]  tbl_step = adr_i[7:5];
    wire [2:0]  tbl_fld  = adr_i[4:2];

    logic [31:0] ctrl_ff;
    logic [15:0] cnt_unit_ff, tol_ff, loss_lim_ff;
    logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff;
    wire  [3:0] src_sel   = ctrl_ff[CTRL_SRC_LSB +: 4];
    wire  [2:0] fb_type   = ctrl_ff[CTRL_FB_LSB +: 3];
    wire  [2:0] mode_sel  = ctrl_ff[CTRL_MODE_LSB +: 3];
    wire        pos_enable = (src_sel == SRC_POSITION) &&
                             (fb_type == FB_QUAD || fb_type == FB_QUAD_CHK);

    // Step table
    logic [2:0]  step_ff, nxt_step;
    logic [15:0] e_whole, e_freq, e_dwell, e_logic;
    logic [6:0]  e_frac;
    eps_step_mem u_mem (
        .clk_i      (clk_i),
        .we_i       (bus_wr & tbl_hit),
        .wr_step_i  (tbl_step),
        .wr_field_i (tbl_fld),
        .wr_data_i  (dat_i[15:0]),
        .rd_step_i  (nxt_step),
        .whole_o    (e_whole),
        .frac_o     (e_frac),
        .freq_o     (e_freq),
        .dwell_o    (e_dwell),
        .logic_o    (e_logic)
    );

    // Quadrature and single channel decoding
    logic        a_q_ff, b_q_ff;
    logic signed [31:0] pos_ff;
    logic signed [15:0] win_pos_ff, meas_ff;
    wire quad_step = (enc_a_i ^ a_q_ff) ^ (enc_b_i ^ b_q_ff);
    wire quad_up   = enc_a_i ^ b_q_ff;
    wire quad_mode = (fb_type == FB_QUAD) || (fb_type == FB_QUAD_CHK);
    wire a_rise    = enc_a_i & ~a_q_ff;
    wire single_mode = (fb_type == FB_PULSE) || (fb_type == FB_SINGLE) || (fb_type == FB_SINGLE_CHK);

    // Loss window and checks
    logic [31:0] win_cnt_ff;
    wire win_end = (win_cnt_ff == 32'(LOSS_CYC - 1));
    wire signed [16:0] exp_s  = 17'(signed'(expected_cnt_i));
    wire signed [16:0] diff_s = 17'(meas_ff) - exp_s;
    wire [16:0] diff_abs  = diff_s[16] ? 17'(-diff_s) : 17'(diff_s);
    wire signed [16:0] lim_s = 17'({1'b0, loss_lim_ff});
    wire loss_chk  = (fb_type == FB_SINGLE_CHK) || (fb_type == FB_QUAD_CHK);
    wire dir_bad   = (fb_type == FB_QUAD_CHK) &&
                     ((exp_s > lim_s && 17'(meas_ff) < -lim_s) || (exp_s < -lim_s && 17'(meas_ff) > lim_s));
    wire loss_bad  = loss_chk && (diff_abs > 17'({1'b0, loss_lim_ff}));

    // Target arithmetic: whole units plus hundredths, scaled by counts per unit
    wire [31:0] whole_cnt = e_whole * cnt_unit_ff;
    wire [22:0] frac_raw  = 23'(e_frac) * 23'(cnt_unit_ff);
    wire [36:0] frac_mul  = frac_raw * FRAC_SCALE;
    wire [31:0] dist_cnt  = whole_cnt + 32'(frac_mul >> FRAC_SHIFT);
    wire        logic_on  = (mode_sel >= MODE_STEP);
    wire [3:0]  d0 = e_logic[3:0];
    wire [3:0]  d1 = e_logic[7:4];
    wire [3:0]  d2 = e_logic[11:8];
    wire [3:0]  d3 = logic_on ? e_logic[15:12] : 4'h0;
    logic signed [31:0] target_ff;
    wire signed [31:0] dist_s  = d3[1] ? -signed'(dist_cnt) : signed'(dist_cnt);
    wire signed [31:0] nxt_tgt = d3[0] ? target_ff + dist_s : dist_s;
    wire signed [31:0] err_s   = pos_ff - target_ff;
    wire [31:0] err_abs = err_s[31] ? 32'(-err_s) : 32'(err_s);
    wire at_pos = err_abs <= 32'(tol_ff);

    // Dwell timer, restarted on entry to each step
    logic [31:0] unit_cnt_ff;
    logic [15:0] dwell_cnt_ff;
    wire tdone = dwell_cnt_ff >= e_dwell;

    function automatic logic cond_met(input logic [3:0] c, input logic t, input logic i1, input logic i2);
        unique case (c)
            4'h0: cond_met = 1'b1;
            4'h1: cond_met = t;
            4'h2: cond_met = i1;
            4'h3: cond_met = i2;
            4'h4: cond_met = ~i1;
            4'h5: cond_met = ~i2;
            4'h6: cond_met = i1 | i2;
            4'h7: cond_met = i1 & i2;
            4'h8: cond_met = ~(i1 | i2);
            4'h9: cond_met = i1 & ~i2;
            4'hA: cond_met = i2 & ~i1;
            4'hB: cond_met = t & i1;
            4'hC: cond_met = t & i2;
            4'hD: cond_met = t & ~i1;
            4'hE: cond_met = t & ~i2;
            4'hF: cond_met = 1'b0;
        endcase
    endfunction

    wire jump_go = (d1 != LOGIC_IGNORE) && cond_met(d1, tdone, logic_in1_i, logic_in2_i);
    wire next_go = (d0 != LOGIC_IGNORE) && cond_met(d0, tdone, logic_in1_i, logic_in2_i);

    // Sequencer
    eps_state_t state_ff, nxt_state;
    logic run_q_ff, fault_ff, end_normal_ff, end_coast_ff;
    logic [2:0] last_step_ff;
    wire run_rise = run_i & ~run_q_ff;
    wire [2:0] start_step = (mode_sel == MODE_PRESET || mode_sel == MODE_INPUT_START) ? preset_sel_i :
                            (mode_sel == MODE_RESUME_LAST) ? last_step_ff : 3'h0;
    logic ev_end, ev_fault;

    always_comb begin
        nxt_state = state_ff;
        nxt_step  = step_ff;
        ev_end    = 1'b0;
        ev_fault  = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                if (run_rise && pos_enable && !fault_ff) begin
                    nxt_step  = start_step;
                    nxt_state = ST_LOAD;
                end
            end
            ST_LOAD: nxt_state = ST_RUN;
            ST_RUN: begin
                if (!run_i || !pos_enable) begin
                    nxt_state = ST_IDLE;
                end else if (win_end && (loss_bad || dir_bad)) begin
                    ev_fault  = 1'b1;
                    nxt_state = ST_IDLE;
                end else if (mode_sel == MODE_PRESET) begin
                    if (preset_sel_i != step_ff) begin
                        nxt_step  = preset_sel_i;
                        nxt_state = ST_LOAD;
                    end
                end else if (mode_sel == MODE_TIMED) begin
                    if (tdone) begin
                        nxt_step  = step_ff + 3'h1;
                        nxt_state = ST_LOAD;
                    end
                end else if (jump_go) begin
                    if (!d2[3]) begin
                        nxt_step  = d2[2:0];
                        nxt_state = ST_LOAD;
                    end else begin
                        ev_end    = 1'b1;
                        ev_fault  = (d2 == JUMP_END_FAULT);
                        nxt_state = ST_END;
                    end
                end else if (next_go) begin
                    nxt_step  = step_ff + 3'h1;
                    nxt_state = ST_LOAD;
                end
            end
            ST_END: begin
                if (!run_i) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    wire [IRQ_W-1:0] irq_evt = {ev_fault, ev_end, state_ff == ST_LOAD, at_pos & ~at_position_o};
    wire clr_wr = bus_wr && !tbl_hit && adr_i == REG_IRQ_CLR;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff      <= ST_IDLE;
            step_ff       <= 3'h0;
            last_step_ff  <= 3'h0;
            run_q_ff      <= 1'b0;
            target_ff     <= '0;
            fault_ff      <= 1'b0;
            end_normal_ff <= 1'b0;
            end_coast_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            step_ff  <= nxt_step;
            run_q_ff <= run_i;
            if (state_ff == ST_LOAD) begin
                target_ff <= nxt_tgt;
            end
            if (state_ff == ST_RUN && nxt_state == ST_IDLE) begin
                last_step_ff <= step_ff;
            end
            if (ev_fault) begin
                fault_ff <= 1'b1;
            end else if (clr_wr && dat_i[IRQ_FAULT]) begin
                fault_ff <= 1'b0;
            end
            if (ev_end) begin
                end_normal_ff <= (d2 != JUMP_END_COAST);
                end_coast_ff  <= (d2 == JUMP_END_COAST);
            end else if (nxt_state == ST_IDLE) begin
                end_normal_ff <= 1'b0;
                end_coast_ff  <= 1'b0;
            end
        end
    end

    // Encoder counting and dwell timing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_q_ff       <= 1'b0;
            b_q_ff       <= 1'b0;
            pos_ff       <= '0;
            win_pos_ff   <= '0;
            meas_ff      <= '0;
            win_cnt_ff   <= '0;
            unit_cnt_ff  <= '0;
            dwell_cnt_ff <= '0;
        end else begin
            a_q_ff <= enc_a_i;
            b_q_ff <= enc_b_i;
            if (quad_mode && quad_step) begin
                pos_ff <= quad_up ? pos_ff + 32'sd1 : pos_ff - 32'sd1;
            end else if (single_mode && a_rise) begin
                win_pos_ff <= win_pos_ff + 16'sd1;
            end
            win_cnt_ff <= win_end ? '0 : win_cnt_ff + 32'd1;
            if (win_end) begin
                meas_ff <= quad_mode ? 16'(pos_ff) - win_pos_ff : win_pos_ff;
                win_pos_ff <= quad_mode ? 16'(pos_ff) : 16'sd0;
            end
            if (state_ff == ST_LOAD) begin
                unit_cnt_ff  <= '0;
                dwell_cnt_ff <= '0;
            end else if (unit_cnt_ff == 32'(DWELL_CYC - 1)) begin
                unit_cnt_ff <= '0;
                if (dwell_cnt_ff != 16'hFFFF) begin
                    dwell_cnt_ff <= dwell_cnt_ff + 16'h0001;
                end
            end else begin
                unit_cnt_ff <= unit_cnt_ff + 32'd1;
            end
        end
    end

    // Registers, interrupts and outputs
    logic [31:0] rd_data;
    always_comb begin
        unique case (adr_i)
            REG_CTRL:     rd_data = ctrl_ff;
            REG_CNT_UNIT: rd_data = {16'h0000, cnt_unit_ff};
            REG_TOL:      rd_data = {16'h0000, tol_ff};
            REG_POSITION: rd_data = pos_ff;
            REG_STATUS:   rd_data = {20'h00000, state_ff, fault_ff, at_position_o, 3'b000, step_ff};
            REG_IRQ_STAT: rd_data = {28'h0000000, irq_stat_ff};
            REG_IRQ_EN:   rd_data = {28'h0000000, irq_en_ff};
            REG_LOSS_LIM: rd_data = {16'h0000, loss_lim_ff};
            REG_CMD_POS:  rd_data = target_ff;
            default:      rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff     <= CTRL_RESET;
            cnt_unit_ff <= CNT_UNIT_RST;
            tol_ff      <= TOL_RST;
            loss_lim_ff <= LOSS_LIM_RST;
            irq_en_ff   <= '0;
            irq_stat_ff <= '0;
            ack_o       <= 1'b0;
            dat_o       <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? rd_data : 32'h0000_0000;
            if (bus_wr && !tbl_hit) begin
                unique case (adr_i)
                    REG_CTRL:     ctrl_ff     <= dat_i;
                    REG_CNT_UNIT: cnt_unit_ff <= dat_i[15:0];
                    REG_TOL:      tol_ff      <= dat_i[15:0];
                    REG_IRQ_EN:   irq_en_ff   <= dat_i[IRQ_W-1:0];
                    REG_LOSS_LIM: loss_lim_ff <= dat_i[15:0];
                    default: ;
                endcase
            end
            // A new event wins over a clear in the same cycle
            irq_stat_ff <= (irq_stat_ff & ~(clr_wr ? dat_i[IRQ_W-1:0] : '0)) | irq_evt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_position_o <= '0;
            freq_limit_o   <= '0;
            step_o         <= '0;
            accel2_sel_o   <= 1'b0;
            step_output_o  <= 1'b0;
            at_position_o  <= 1'b0;
            pos_active_o   <= 1'b0;
            stop_normal_o  <= 1'b0;
            stop_coast_o   <= 1'b0;
            fault_o        <= 1'b0;
            irq_o          <= 1'b0;
        end else begin
            cmd_position_o <= target_ff;
            freq_limit_o   <= (state_ff == ST_RUN) ? e_freq : 16'h0000;
            step_o         <= step_ff;
            accel2_sel_o   <= d3[3];
            step_output_o  <= d3[2];
            at_position_o  <= at_pos;
            pos_active_o   <= (state_ff == ST_RUN) || (state_ff == ST_LOAD);
            stop_normal_o  <= end_normal_ff;
            stop_coast_o   <= end_coast_ff;
            fault_o        <= fault_ff;
            irq_o          <= |(irq_stat_ff & irq_en_ff);
        end
    end
endmodule // eps_seq

// [verification/eps_seq_properties.sv]
// Concurrent checks on the port behaviour of the step sequencer
module eps_seq_properties
    import eps_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [8:0]  adr_i,
    input wire logic        we_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    input wire logic        run_i,
    input wire logic [31:0] cmd_position_o,
    input wire logic [15:0] freq_limit_o,
    input wire logic        at_position_o,
    input wire logic        pos_active_o,
    input wire logic        stop_normal_o,
    input wire logic        stop_coast_o,
    input wire logic        fault_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not acked");
    read_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
    // Reset is the antecedent here, so the default disable is overridden
    pos_reset_a: assert property (disable iff (1'b0) rst_i |=> cmd_position_o == 32'h0 && !pos_active_o && !fault_o)
        else $error("outputs not cleared by reset");
    stop_hold_a: assert property (stop_normal_o && run_i |=> stop_normal_o) else $error("stop dropped");
    stop_excl_a: assert property (!(stop_normal_o && stop_coast_o)) else $error("two stop kinds");
    fault_stick_a: assert property (fault_o && !(cyc_i && we_i && adr_i == REG_IRQ_CLR) |=> fault_o)
        else $error("fault cleared on its own");
    freq_idle_a: assert property (!pos_active_o ##1 !pos_active_o |-> freq_limit_o == 16'h0)
        else $error("frequency limit while idle");
    home_pos_a: assert property ($fell(rst_i) |-> ##[1:3] at_position_o) else $error("not at home");
    cover property ($rose(stop_coast_o));
    cover property ($rose(fault_o));
    cover property (cyc_i && we_i && ack_o);
endmodule // eps_seq_properties

// [verification/eps_enc_model.sv]
// Incremental quadrature encoder model driving the two channel levels
module eps_enc_model (
    input  wire logic clk_i,
    input  wire logic move_i,
    input  wire logic dir_i,
    output logic      enc_a_o,
    output logic      enc_b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_ff;
    initial ph_ff = 2'h0;
    // Gray order 00,10,11,01: channel A leads B on forward motion, so only one channel moves per count
    always @(posedge clk_i) if (move_i) ph_ff <= dir_i ? ph_ff + 2'h1 : ph_ff - 2'h1;
    assign enc_a_o = ph_ff[1] ^ ph_ff[0];
    assign enc_b_o = ph_ff[1];
endmodule // eps_enc_model

// [verification/eps_seq_test.sv]
// Self-checking bench of the encoder position step sequencer
module eps_seq_test
    import eps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_i, we, cyc, run, mv, dir, ea, eb, ack, atp, act, sn, sc, flt, irq, a2, so, li;
    logic [8:0]  adr;
    logic [2:0]  pre, stp;
    logic [15:0] xc, frq;
    logic [31:0] wd, rd, dat, cpos;
    int          err_count, checks_done, cpu, tol, n, t, p, s, last;
    eps_seq #(.DWELL_CYC(10), .LOSS_CYC(64)) eps_seq_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wd),
        .dat_o(dat), .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(cyc), .ack_o(ack), .enc_a_i(ea), .enc_b_i(eb),
        .run_i(run), .logic_in1_i(li), .logic_in2_i(1'b0), .preset_sel_i(pre), .expected_cnt_i(xc),
        .cmd_position_o(cpos), .freq_limit_o(frq), .step_o(stp), .accel2_sel_o(a2), .step_output_o(so),
        .at_position_o(atp), .pos_active_o(act), .stop_normal_o(sn), .stop_coast_o(sc), .fault_o(flt), .irq_o(irq));
    eps_enc_model eps_enc_model_i (.clk_i(clk_i), .move_i(mv), .dir_i(dir), .enc_a_o(ea), .enc_b_o(eb));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic print_verdict();
        if (err_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until the ack edge; cyc drops for a cycle before the next one
    task automatic wb(input logic [8:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        we  <= w;
        wd  <= d;
        cyc <= 1'b1;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = dat;
        cyc <= 1'b0;
    endtask
    task automatic enc(input int k, input logic d);
        repeat (k) begin
            @(posedge clk_i);
            mv  <= 1'b1;
            dir <= d;
            @(posedge clk_i);
            mv  <= 1'b0;
        end
    endtask
    task automatic till(input logic [2:0] s);
        for (int i = 0; i < 100 && stp !== s; i++) @(posedge clk_i);
    endtask
    function automatic logic [31:0] tgt(input int k);
        return 32'((k + 1) * cpu + ((k * 11 * cpu * int'(FRAC_SCALE)) >> FRAC_SHIFT));
    endfunction
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end
    initial begin
        {rst_i, we, cyc, run, mv, dir, li, adr, pre, xc, wd, err_count, checks_done, last} = '0;
        rst_i = 1'b1;
        void'($urandom(79));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(REG_CNT_UNIT, 1'b0, 0);
        cmp("cnt_unit", 1, rd);
        wb(REG_LOSS_LIM, 1'b0, 0);
        cmp("loss_lim", 32'h10, rd);
        wb(9'h02C, 1'b0, 0);
        cmp("unmapped", 0, rd);
        for (int i = 0; i < 2; i++) begin
            wb(REG_CTRL, 1'b1, i ? 32'h029 : 32'h048);
            run <= 1'b1;
            repeat (4) @(posedge clk_i);
            cmp("inactive", 0, act);
            run <= 1'b0;
        end
        wb(REG_CTRL, 1'b1, 32'h049);
        n = $urandom_range(1, 300);
        t = $urandom_range(0, 400);
        enc(n, 1'b1);
        enc(t, 1'b0);
        p = n - t;
        wb(REG_POSITION, 1'b0, 0);
        cmp("count", p, rd);
        cpu = $urandom_range(1, 60);
        tol = $urandom_range(0, 200);
        wb(REG_CNT_UNIT, 1'b1, cpu);
        wb(REG_TOL, 1'b1, tol);
        wb(REG_IRQ_EN, 1'b1, 32'h2);
        for (int i = 0; i < 40; i++) wb(9'(256 + (i / 5) * 32 + (i % 5) * 4), 1'b1,
            (i % 5 == 0) ? i / 5 + 1 : (i % 5 == 1) ? (i / 5) * 11 : (i % 5 == 2) ? 32'h100 + i / 5 :
            (i % 5 == 3) ? 1 : 32'h00F1);
        run <= 1'b1;
        repeat (5) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            s = i % 8;
            till(3'(s));
            repeat (3) @(posedge clk_i);
            cmp("step", s, stp);
            cmp("cmd_pos", tgt(s), cpos);
            cmp("freq", 32'h100 + s, frq);
            n = p - int'(tgt(s));
            cmp("at_pos", ((n < 0 ? -n : n) <= tol), atp);
        end
        run <= 1'b0;
        cmp("irq_on", 1, irq);
        wb(REG_IRQ_EN, 1'b1, 0);
        repeat (2) @(posedge clk_i);
        cmp("irq_mask", 0, irq);
        wb(REG_IRQ_STAT, 1'b0, 0);
        cmp("irq_stat", 2, rd & 2);
        wb(REG_IRQ_CLR, 1'b1, 2);
        wb(REG_IRQ_STAT, 1'b0, 0);
        cmp("irq_clear", 0, rd & 2);
        wb(REG_CTRL, 1'b1, 32'h149);
        for (int i = 0; i < 3; i++) begin
            pre <= 3'($urandom_range(0, 7));
            run <= 1'b1;
            repeat (6) @(posedge clk_i);
            cmp("preset_step", pre, stp);
            cmp("preset_pos", tgt(pre), cpos);
        end
        run <= 1'b0;
        for (int m = 2; m <= 4; m++) begin
            pre <= 3'($urandom_range(0, 5));
            wb(REG_CTRL, 1'b1, 32'h049 | (m << 8));
            run <= 1'b1;
            repeat (5) @(posedge clk_i);
            s = (m == 2) ? 0 : (m == 3) ? pre : last;
            cmp("start_step", s, stp);
            till(3'(s + 1));
            cmp("next_step", s + 1, stp);
            last = s + 1;
            run <= 1'b0;
        end
        // Mode 2 so that every run starts at step 0, whose jump waits for input 1
        wb(REG_CTRL, 1'b1, 32'h249);
        for (int c = 8; c <= 10; c++) begin
            wb(9'h110, 1'b1, 32'(c << 8) | 32'hC02F);
            run <= 1'b1;
            repeat (8) @(posedge clk_i);
            cmp("no_jump", 0, sn | sc | flt);
            li <= 1'b1;
            repeat (4) @(posedge clk_i);
            cmp("stop_normal", c != 9, sn);
            cmp("stop_coast", c == 9, sc);
            cmp("end_fault", c == 10, flt);
            cmp("accel2", 1, a2);
            cmp("step_out", 1, so);
            run <= 1'b0;
            li  <= 1'b0;
            wb(REG_IRQ_CLR, 1'b1, 32'hF);
        end
        // Encoder stands still while expected_cnt_i asks for motion
        wb(REG_CTRL, 1'b1, 32'h059);
        xc  <= 16'd100;
        run <= 1'b1;
        repeat (200) @(posedge clk_i);
        cmp("loss_fault", 1, flt);
        print_verdict();
    end
endmodule // eps_seq_test
bind eps_seq eps_seq_properties eps_seq_properties_i (.clk_i, .rst_i, .adr_i, .we_i, .cyc_i, .stb_i, .ack_o,
    .dat_o, .run_i, .cmd_position_o, .freq_limit_o, .at_position_o, .pos_active_o, .stop_normal_o, .stop_coast_o,
    .fault_o);
